// ===== src/token_pkg.sv
package token_pkg;
  // ==========================================================
  // Timebase
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned BAUD_DEFAULT  = 9600;
  localparam logic [3:0]  BITS_PER_CHAR = 4'hb;      // Start, 8 data, parity, stop
  // ==========================================================
  // Configuration reset values
  localparam logic [7:0]  GAP_POLL_DEFAULT  = 8'h0a;  // Ten token holds
  localparam logic [6:0]  TOP_LIMIT_DEFAULT = 7'h1f;  // Station 31
  // ==========================================================
  // Frame lengths in characters
  localparam logic [7:0]  PROBE_CHARS = 8'h06;
  localparam logic [7:0]  TOKEN_CHARS = 8'h03;
  // Target rotation budget per station slot, in bit times
  localparam int unsigned TARGET_BITS_PER_STA = 300;
  // ==========================================================
  // Widths
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned ROT_W  = 28;
  // ==========================================================
  // Token hold sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_REQ   = 4'h2,
    ST_PROBE = 4'h4,
    ST_PASS  = 4'h8
  } hold_state_t;
endpackage : token_pkg

// ===== src/char_if.sv
interface char_if;
  // Frame request toward the character timer
  logic       start;
  logic [7:0] nchars;
  // Completion back to the sequencer
  logic       busy;
  logic       done;

  modport seq   (output start, output nchars, input busy, input done);
  modport timer (input start, input nchars, output busy, output done);
endinterface : char_if

// ===== src/char_timer.sv
module char_timer #(
  parameter int unsigned CYC_PER_BIT = 1041
) (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // Frame channel
  char_if.timer     ch
);
  logic [11:0] bits_left_r;
  logic [15:0] cyc_r;
  logic        busy_r;
  logic        done_r;

  // ==========================================================
  // Bit period counter; each character spans eleven periods
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      bits_left_r <= 12'h000;
      cyc_r       <= 16'h0000;
      busy_r      <= 1'b0;
      done_r      <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && ch.start && ch.nchars != 8'h00) begin
        bits_left_r <= 12'(ch.nchars) * 12'(token_pkg::BITS_PER_CHAR);
        cyc_r       <= 16'(CYC_PER_BIT - 1);
        busy_r      <= 1'b1;
      end else if (busy_r) begin
        if (cyc_r != 16'h0000) begin
          cyc_r <= cyc_r - 16'h0001;
        end else if (bits_left_r == 12'h001) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          bits_left_r <= bits_left_r - 12'h001;
          cyc_r       <= 16'(CYC_PER_BIT - 1);
        end
      end else if (ch.start) begin
        done_r <= 1'b1;                             // Empty frame ends at once
      end
    end
  end

  assign ch.busy = busy_r;
  assign ch.done = done_r;
endmodule : char_timer

// ===== src/token_master.sv
module token_master #(
  parameter int unsigned BAUD        = token_pkg::BAUD_DEFAULT,
  parameter int unsigned CYC_PER_BIT = token_pkg::CLK_HZ / BAUD
) (
  // Clock and reset
  input  wire logic                         CLK,
  input  wire logic                         RST,
  // Port configuration
  input  wire logic                         MASTER_MODE,
  input  wire logic                         CFG_LOAD,
  input  wire logic [7:0]                   GAP_POLL_FACTOR,
  input  wire logic [token_pkg::ADDR_W-1:0] TOP_STATION_LIMIT,
  input  wire logic [token_pkg::ADDR_W-1:0] OWN_ADDR,
  input  wire logic [token_pkg::ADDR_W-1:0] NEXT_MASTER,
  // Link events
  input  wire logic                         TOKEN_IN,
  // Request source
  input  wire logic                         REQ_PENDING,
  input  wire logic [token_pkg::ADDR_W-1:0] REQ_ADDR,
  input  wire logic [7:0]                   REQ_CHARS,
  // Frame starts toward the line
  output logic                              REQ_START,
  output logic [token_pkg::ADDR_W-1:0]      REQ_DEST,
  output logic                              PROBE_START,
  output logic [token_pkg::ADDR_W-1:0]      PROBE_DEST,
  output logic                              TOKEN_PASS,
  output logic [token_pkg::ADDR_W-1:0]      TOKEN_DEST,
  // Status
  output logic                              HOLDING,
  output logic                              ROT_OK
);
  localparam int unsigned AW = token_pkg::ADDR_W;
  localparam int unsigned RW = token_pkg::ROT_W;

  char_if ch ();

  token_pkg::hold_state_t state_r;
  logic [7:0]    gap_poll_factor_r;
  logic [AW-1:0] top_station_limit_r;
  logic [7:0]    hold_cnt_r;
  logic          probe_due_r;
  logic [AW-1:0] probe_ptr_r;
  logic [RW-1:0] rot_cnt_r;
  logic          rot_run_r;
  logic          rot_ok_r;
  logic          wait_r;
  logic          start_r;
  logic [7:0]    nchars_r;
  logic [AW-1:0] gap_first;
  logic [AW-1:0] probe_nxt;
  logic          gap_open;
  logic [RW-1:0] target_cyc;

  // ==========================================================
  // Address stepping, wrapping above the top station limit
  function automatic logic [AW-1:0] step_addr(input logic [AW-1:0] a, input logic [AW-1:0] lim);
    step_addr = (a >= lim) ? '0 : AW'(a + 1'b1);
  endfunction : step_addr

  // Steps from one address to another, wrapping above the limit
  function automatic logic [AW:0] ring_span(input logic [AW-1:0] from, input logic [AW-1:0] to,
                                            input logic [AW-1:0] lim);
    if (to > from) begin
      ring_span = {1'b0, to} - {1'b0, from};
    end else begin
      ring_span = {1'b0, to} + {1'b0, lim} + {{AW{1'b0}}, 1'b1} - {1'b0, from};
    end
  endfunction : ring_span

  // True when an address lies strictly between this station and its successor
  function automatic logic gap_has(input logic [AW-1:0] a, input logic [AW-1:0] own,
                                   input logic [AW-1:0] nxt, input logic [AW-1:0] lim);
    gap_has = (a <= lim) && (a != own) && (ring_span(own, a, lim) < ring_span(own, nxt, lim));
  endfunction : gap_has

  // Frame timing in whole characters of eleven bit periods
  char_timer #(.CYC_PER_BIT(CYC_PER_BIT)) u_timer (
    .CLK (CLK),
    .RST (RST),
    .ch  (ch)
  );

  assign ch.start  = start_r;
  assign ch.nchars = nchars_r;

  // ==========================================================
  // Gap detection and next probe address
  assign gap_first = step_addr(OWN_ADDR, top_station_limit_r);
  assign gap_open  = (gap_first != NEXT_MASTER) && (gap_first != OWN_ADDR);
  always_comb begin
    probe_nxt = step_addr(probe_ptr_r, top_station_limit_r);
    if (!gap_has(probe_nxt, OWN_ADDR, NEXT_MASTER, top_station_limit_r)) begin
      probe_nxt = gap_first;
    end
  end

  // Target rotation from station count and bit time
  assign target_cyc = RW'((32'(top_station_limit_r) + 32'd1) * token_pkg::TARGET_BITS_PER_STA
                          * CYC_PER_BIT);

  // ==========================================================
  // Per-port configuration held locally
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      gap_poll_factor_r   <= token_pkg::GAP_POLL_DEFAULT;
      top_station_limit_r <= token_pkg::TOP_LIMIT_DEFAULT;
    end else if (CFG_LOAD) begin
      gap_poll_factor_r   <= (GAP_POLL_FACTOR == 8'h00) ? 8'h01 : GAP_POLL_FACTOR;
      top_station_limit_r <= TOP_STATION_LIMIT;
    end
  end

  // ==========================================================
  // Token hold counter deciding when a probe is due
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hold_cnt_r  <= 8'h00;
      probe_due_r <= 1'b0;
    end else if (state_r == token_pkg::ST_IDLE && TOKEN_IN && MASTER_MODE) begin
      if (hold_cnt_r + 8'h01 >= gap_poll_factor_r) begin
        hold_cnt_r  <= 8'h00;
        probe_due_r <= 1'b1;
      end else begin
        hold_cnt_r  <= hold_cnt_r + 8'h01;
        probe_due_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Rotation timer from token pass to token return
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rot_cnt_r <= '0;
      rot_run_r <= 1'b0;
      rot_ok_r  <= 1'b1;
    end else if (TOKEN_IN && state_r == token_pkg::ST_IDLE) begin
      rot_run_r <= 1'b0;
      if (rot_run_r) begin
        rot_ok_r <= (rot_cnt_r < target_cyc);
      end
    end else if (TOKEN_PASS) begin
      rot_cnt_r <= '0;
      rot_run_r <= 1'b1;
    end else if (rot_run_r && rot_cnt_r != '1) begin
      rot_cnt_r <= rot_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // Hold sequencer: request when pending and within rotation budget, optional probe, token pass
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_r     <= token_pkg::ST_IDLE;
      wait_r      <= 1'b0;
      start_r     <= 1'b0;
      nchars_r    <= 8'h00;
      probe_ptr_r <= '0;
      REQ_START   <= 1'b0;
      REQ_DEST    <= '0;
      PROBE_START <= 1'b0;
      PROBE_DEST  <= '0;
      TOKEN_PASS  <= 1'b0;
      TOKEN_DEST  <= '0;
      HOLDING     <= 1'b0;
    end else begin
      start_r     <= 1'b0;
      REQ_START   <= 1'b0;
      PROBE_START <= 1'b0;
      TOKEN_PASS  <= 1'b0;
      unique case (state_r)
        token_pkg::ST_IDLE: begin
          if (TOKEN_IN && MASTER_MODE) begin
            state_r <= token_pkg::ST_REQ;
            HOLDING <= 1'b1;
            wait_r  <= 1'b0;
            if (!gap_has(probe_ptr_r, OWN_ADDR, NEXT_MASTER, top_station_limit_r)) begin
              probe_ptr_r <= OWN_ADDR;                // Restart the walk inside the gap
            end
          end
        end
        token_pkg::ST_REQ: begin
          if (!wait_r) begin
            if (REQ_PENDING && rot_ok_r) begin
              REQ_START <= 1'b1;
              REQ_DEST  <= REQ_ADDR;
              start_r   <= 1'b1;
              nchars_r  <= REQ_CHARS;
              wait_r    <= 1'b1;
            end else begin
              state_r <= token_pkg::ST_PROBE;
            end
          end else if (ch.done) begin
            wait_r  <= 1'b0;
            state_r <= token_pkg::ST_PROBE;
          end
        end
        token_pkg::ST_PROBE: begin
          if (!wait_r) begin
            if (probe_due_r && gap_open) begin
              PROBE_START <= 1'b1;
              PROBE_DEST  <= probe_nxt;
              probe_ptr_r <= probe_nxt;
              start_r     <= 1'b1;
              nchars_r    <= token_pkg::PROBE_CHARS;
              wait_r      <= 1'b1;
            end else begin
              state_r <= token_pkg::ST_PASS;
            end
          end else if (ch.done) begin
            wait_r  <= 1'b0;
            state_r <= token_pkg::ST_PASS;
          end
        end
        token_pkg::ST_PASS: begin
          if (!wait_r) begin
            start_r  <= 1'b1;
            nchars_r <= token_pkg::TOKEN_CHARS;
            wait_r   <= 1'b1;
          end else if (ch.done) begin
            TOKEN_PASS <= 1'b1;
            TOKEN_DEST <= NEXT_MASTER;
            HOLDING    <= 1'b0;
            wait_r     <= 1'b0;
            state_r    <= token_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  assign ROT_OK = rot_ok_r;
endmodule : token_master

// ===== tb/token_checker.sv
// ==========================================
// Port checker for the token hold sequencer
module token_checker (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RST,
  // Configuration and link inputs
  input wire logic       MASTER_MODE,
  input wire logic [6:0] TOP_STATION_LIMIT,
  input wire logic [6:0] OWN_ADDR,
  input wire logic [6:0] NEXT_MASTER,
  input wire logic       TOKEN_IN,
  input wire logic [6:0] REQ_ADDR,
  // Frame starts and status
  input wire logic       REQ_START,
  input wire logic [6:0] REQ_DEST,
  input wire logic       PROBE_START,
  input wire logic [6:0] PROBE_DEST,
  input wire logic       TOKEN_PASS,
  input wire logic [6:0] TOKEN_DEST,
  input wire logic       HOLDING,
  input wire logic       ROT_OK
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Steps of one token hold
  sequence take_s; TOKEN_IN && !HOLDING && MASTER_MODE; endsequence
  sequence pass_s; TOKEN_PASS && TOKEN_DEST == NEXT_MASTER; endsequence
  take_tok_a: assert property (take_s |=> HOLDING) else $error("token not taken");
  req_hold_a: assert property (REQ_START |-> HOLDING) else $error("request without token");
  probe_hold_a: assert property (PROBE_START |-> HOLDING && !REQ_START) else $error("bad probe");
  pass_dest_a: assert property (TOKEN_PASS |-> pass_s ##0 !HOLDING) else $error("bad pass");
  idle_mode_a: assert property (!MASTER_MODE && !HOLDING |=> !HOLDING) else $error("hold in slave");
  req_dest_a: assert property (REQ_START |-> REQ_DEST == $past(REQ_ADDR)) else $error("bad dest");
  probe_gap_a: assert property (PROBE_START |-> PROBE_DEST != NEXT_MASTER && PROBE_DEST != OWN_ADDR
    && PROBE_DEST <= TOP_STATION_LIMIT) else $error("probe outside gap");
  rot_gate_a: assert property (REQ_START |-> $past(ROT_OK)) else $error("request over budget");
  frame_len_a: assert property (REQ_START |=> !TOKEN_PASS [*8]) else $error("frame too short");
endmodule : token_checker

bind token_master token_checker chk_i (
  .CLK(CLK), .RST(RST), .MASTER_MODE(MASTER_MODE), .TOP_STATION_LIMIT(TOP_STATION_LIMIT),
  .OWN_ADDR(OWN_ADDR), .NEXT_MASTER(NEXT_MASTER), .TOKEN_IN(TOKEN_IN), .REQ_ADDR(REQ_ADDR),
  .REQ_START(REQ_START), .REQ_DEST(REQ_DEST), .PROBE_START(PROBE_START), .PROBE_DEST(PROBE_DEST),
  .TOKEN_PASS(TOKEN_PASS), .TOKEN_DEST(TOKEN_DEST), .HOLDING(HOLDING), .ROT_OK(ROT_OK));

// ===== tb/ring_partner.sv
// ==========================================
// Rest of the logical ring seen from one master
module ring_partner (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Token traffic
  input  wire logic token_pass,
  input  wire logic [31:0] rot_delay,
  output logic             tok
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt_r;
  logic tok_r;
  logic run_r;
  assign tok = tok_r;
  // Other masters keep the token a bounded time, then hand it back once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 0;
      tok_r <= 1'b0;
      run_r <= 1'b1;
    end else begin
      tok_r <= run_r && (cnt_r == rot_delay);
      if (token_pass) begin
        cnt_r <= 0;
        run_r <= 1'b1;
      end else if (run_r && cnt_r == rot_delay) begin
        cnt_r <= 0;
        run_r <= 1'b0;
      end else if (run_r) begin
        cnt_r <= cnt_r + 1;
      end
    end
  end
endmodule : ring_partner

// ===== tb/test_token_master.sv
module test_token_master;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Stimulus, model state and scenario table
  localparam int CPB = 2;
  logic       clk = 1'b0, rst = 1'b1, mode = 1'b1, load = 1'b0, pend = 1'b1;
  logic [7:0] fac_in = 8'h0a, chars = 8'h01;
  logic [6:0] lim_in = 7'h1f, own = 7'h02, nxt = 7'h06, raddr = 7'h50;
  logic       tok, rq, pb, pass, holding, rot_ok;
  logic [6:0] rq_dest, pb_dest, pass_dest;
  int         delay = 400, n_mismatch = 0, num_checks = 0, seed = 32'hbeaac60c;
  int         rot = 0, pass_t = 0, cnt = 0, fac = 10, lim = 31, n_req, n_prb, s, h, i;
  // Factor, limit, own, successor, holds, rotation delay
  int         sc[6][6] = '{'{10, 31, 2, 6, 10, 400}, '{1, 31, 20, 2, 4, 150}, '{2, 31, 3, 4, 4, 400},
                          '{2, 31, 1, 5, 4, 400}, '{1, 1, 0, 1, 3, 1500}, '{1, 1, 0, 1, 2, 400}};
  always #50 clk = ~clk;
  token_master #(.CYC_PER_BIT(CPB)) uut (
    .CLK(clk), .RST(rst), .MASTER_MODE(mode), .CFG_LOAD(load), .GAP_POLL_FACTOR(fac_in),
    .TOP_STATION_LIMIT(lim_in), .OWN_ADDR(own), .NEXT_MASTER(nxt), .TOKEN_IN(tok),
    .REQ_PENDING(pend), .REQ_ADDR(raddr), .REQ_CHARS(chars), .REQ_START(rq), .REQ_DEST(rq_dest),
    .PROBE_START(pb), .PROBE_DEST(pb_dest), .TOKEN_PASS(pass), .TOKEN_DEST(pass_dest),
    .HOLDING(holding), .ROT_OK(rot_ok));
  ring_partner far_end (.clk(clk), .rst(rst), .token_pass(pass), .rot_delay(delay), .tok(tok));
  // Rotation time in cycles, from the pass to the next accepted token
  always @(negedge clk) begin
    if (pass === 1'b1) pass_t = int'($time / 100);
    if (tok === 1'b1 && holding === 1'b0 && mode === 1'b1) rot = int'($time / 100) - pass_t;
  end
  // ==========================================
  // Comparison, verdict and hold model
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  function automatic logic in_gap(input logic [6:0] d);
    int a;
    a = (own + 1 > lim) ? 0 : own + 1;
    for (int k = 0; k < 128 && a != nxt; k++) begin
      if (7'(a) === d) return 1'b1;
      a = (a + 1 > lim) ? 0 : a + 1;
    end
    return 1'b0;
  endfunction : in_gap
  task automatic hold();
    logic ok;
    logic gap;
    n_req = 0;
    n_prb = 0;
    for (i = 0; i < 4000 && holding !== 1'b1; i++) @(negedge clk);
    ok = rot < (lim + 1) * int'(token_pkg::TARGET_BITS_PER_STA) * CPB;
    gap = in_gap(7'((own + 1 > lim) ? 0 : own + 1));
    for (; i < 4000 && pass !== 1'b1; i++) begin
      @(negedge clk);
      if (rq === 1'b1) begin
        n_req++;
        chk(rq_dest, raddr);
      end
      if (pb === 1'b1) begin
        n_prb++;
        chk(in_gap(pb_dest), 1'b1);
      end
    end
    if (i >= 4000) begin
      n_mismatch++;
      print_verdict();
    end
    cnt++;
    if (cnt >= fac) cnt = 0;
    chk(rot_ok, ok);
    chk(n_req, pend && ok);
    chk(n_prb, cnt == 0 && gap);
    chk(pass_dest, nxt);
  endtask : hold
  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(rot_ok, 1'b1);
    chk(holding, 1'b0);
    for (s = 0; s < 6; s++) begin
      @(posedge clk);
      fac = sc[s][0];
      lim = sc[s][1];
      {fac_in, lim_in, own, nxt} <= {8'(fac), 7'(lim), 7'(sc[s][2]), 7'(sc[s][3])};
      delay <= sc[s][5];
      load <= (s > 0);
      @(posedge clk);
      load <= 1'b0;
      for (h = 0; h < sc[s][4]; h++) begin
        hold();
        @(posedge clk);
        pend <= ($random(seed) & 3) != 0;
        raddr <= 7'($random(seed));
        chars <= 8'(1 + (($random(seed) & 32'h7fffffff) % 3));
      end
      $display("scenario %0d done", s);
    end
    mode <= 1'b0;
    n_req = 0;
    repeat (900) begin
      @(negedge clk);
      if (holding !== 1'b0) n_req++;
    end
    chk(n_req, 0);
    $display("master mode off done");
    print_verdict();
  end
endmodule : test_token_master
